// ==== core/sleep_timer_map.svh ====
// Constants for the sleep timer and deep sleep wake block
`ifndef SLEEP_TIMER_MAP_SVH
`define SLEEP_TIMER_MAP_SVH
// ========================================
// Timer field layout
`define ST_CNT_W          16
`define ST_DIV_W          4
`define ST_DIV_MAX        4'hA
`define ST_CNT_RST        16'h0000
// ========================================
// Calibrated divider
`define ST_CAL_W          8
`define ST_CAL_RST        8'h05
// ========================================
// Wake cause bit positions
`define WK_CMPA           0
`define WK_EXTIRQ         1
`define WK_DEBUG          2
`define WK_SERIAL         3
`define WK_GPIO           4
`define WK_NUM            5
// ========================================
// Save and restore sequence lengths in cycles
`define SAVE_CYCLES       8'h10
`define RESTORE_CYCLES    8'h10
`define GPIO_MON_W        16
`endif

// ==== core/sleep_timer_pkg.sv ====
// Types for the sleep timer and power mode logic
package sleep_timer_pkg;
   // Power controller modes
   typedef enum logic [2:0] {
      PM_ACTIVE,
      PM_IDLE,
      PM_SAVE,
      PM_DEEP,
      PM_RESTORE
   } power_mode_t;
endpackage

// ==== core/sleep_prescaler.sv ====
// Clock source selection and 2^N prescaler for the sleep timer
`timescale 1ns/1ps
`include "sleep_timer_map.svh"
module sleep_prescaler #(
   parameter int DIV_W = `ST_DIV_W
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   // Source ticks
   input  wire logic             cal_tick,
   input  wire logic             xtal_tick,
   input  wire logic             clk_sel,
   input  wire logic [DIV_W-1:0] div_exp,
   // Final timer tick
   output logic                  timer_tick
);
   // Selected source tick
   logic        src_tick;
   // Prescale counter
   logic [9:0]  pre_q;
   // Clamped exponent
   logic [3:0]  n_eff;

   // Source select, 0 calibrated, 1 crystal
   assign src_tick = clk_sel ? xtal_tick : cal_tick;
   // Codes above ten divide by 2^10
   assign n_eff = (div_exp > `ST_DIV_MAX) ? `ST_DIV_MAX : div_exp;

   // Free running prescale counter
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pre_q <= 10'h000;
      end else if (src_tick) begin
         pre_q <= pre_q + 10'h001;
      end
   end

   // Tick when the low N bits are all ones
   always_comb begin
      logic [9:0] mask;
      mask = 10'h000;
      mask = 10'((11'h001 << n_eff) - 11'h001);
      timer_tick = src_tick && ((pre_q & mask) == mask);
   end
endmodule

// ==== core/sleep_timer_power.sv ====
// Sleep timer, wake sources and deep sleep power control
`timescale 1ns/1ps
`include "sleep_timer_map.svh"
module sleep_timer_power #(
   parameter int CNT_W = `ST_CNT_W,
   parameter int CAL_W = `ST_CAL_W,
   parameter int GW    = `GPIO_MON_W
) (
   // Clock and reset
   input  wire logic             mclk,
   input  wire logic             sys_rst,
   // Oscillator ticks, one cycle each
   input  wire logic             rc_tick,
   input  wire logic             xtal_tick,
   // Timer configuration
   input  wire logic             clk_sel,
   input  wire logic [3:0]       div_exp,
   input  wire logic [CAL_W-1:0] cal_div,
   input  wire logic [CNT_W-1:0] cmp_a,
   input  wire logic [CNT_W-1:0] cmp_b,
   input  wire logic             cmp_a_clr,
   input  wire logic             cmp_b_clr,
   // Timer status
   output logic [CNT_W-1:0]      count_q,
   output logic                  cmp_a_flag_q,
   output logic                  cmp_b_flag_q,
   output logic                  rc_mgmt_tick,
   // Power requests from software
   input  wire logic             idle_req,
   input  wire logic             sleep_req,
   input  wire logic             any_irq,
   // Wake sources
   input  wire logic             ext_irq,
   input  wire logic             debug_wake,
   input  wire logic             serial_act,
   input  wire logic             serial_wake_en,
   input  wire logic [GW-1:0]    gpio_in,
   input  wire logic [GW-1:0]    gpio_wake_mask_low,
   // Wake cause record
   input  wire logic             wake_cause_clr,
   output logic [`WK_NUM-1:0]    wake_cause_q,
   // Power outputs
   output sleep_timer_pkg::power_mode_t mode_q,
   output logic                  cpu_halt,
   output logic                  core_pwr_en,
   output logic                  core_rst,
   output logic                  regulator_en,
   output logic                  regulator_output_pin,
   output logic                  pads_ram_pwr,
   output logic                  gpio_freeze,
   output logic                  serial_rx_en,
   output logic                  cpu_save,
   output logic                  cpu_restore
);
   // ========================================
   // Calibrated clock and timer
   logic [CAL_W-1:0] cal_cnt_q;      // Calibration divider counter
   logic             cal_tick;       // Calibrated 1kHz tick
   logic             timer_tick;     // Prescaled timer tick
   logic [GW-1:0]    gpio_prev_q;    // Last sampled GPIO inputs
   logic [`WK_NUM-1:0] wake_ev;      // Wake events this cycle
   logic [7:0]       seq_q;          // Save or restore step counter
   logic             deep_wake;      // Any wake event in deep sleep

   // Last RC tick of a calibrated period; 0 and 1 pass every tick
   function automatic logic cal_last(input logic [CAL_W-1:0] cnt,
                                     input logic [CAL_W-1:0] div);
      return (div <= CAL_W'(1)) || (cnt >= div - CAL_W'(1));
   endfunction

   // RC tick passed raw to chip management
   assign rc_mgmt_tick = rc_tick;

   // Adjustable divider from RC to calibrated clock
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cal_cnt_q <= '0;
      end else if (rc_tick) begin
         if (cal_last(cal_cnt_q, cal_div)) begin
            cal_cnt_q <= '0;
         end else begin
            cal_cnt_q <= cal_cnt_q + CAL_W'(1);
         end
      end
   end
   assign cal_tick = rc_tick && cal_last(cal_cnt_q, cal_div);

   // Source select and prescale
   sleep_prescaler #(
      .DIV_W (4)
   ) u_pre (
      .mclk       (mclk),
      .sys_rst    (sys_rst),
      .cal_tick   (cal_tick),
      .xtal_tick  (xtal_tick),
      .clk_sel    (clk_sel),
      .div_exp    (div_exp),
      .timer_tick (timer_tick)
   );

   // Timer counter, not reset by deep sleep, wraps at max
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         count_q <= `ST_CNT_RST;
      end else if (timer_tick) begin
         count_q <= count_q + CNT_W'(1);
      end
   end

   // Compare A flag, set wins over clear
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cmp_a_flag_q <= 1'b0;
      end else if (timer_tick && count_q == cmp_a) begin
         cmp_a_flag_q <= 1'b1;
      end else if (cmp_a_clr) begin
         cmp_a_flag_q <= 1'b0;
      end
   end

   // Compare B flag, never a wake source
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         cmp_b_flag_q <= 1'b0;
      end else if (timer_tick && count_q == cmp_b) begin
         cmp_b_flag_q <= 1'b1;
      end else if (cmp_b_clr) begin
         cmp_b_flag_q <= 1'b0;
      end
   end

   // ========================================
   // Wake sources
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         gpio_prev_q <= '0;
      end else begin
         gpio_prev_q <= gpio_in;
      end
   end

   // Collect wake events; compare B excluded
   always_comb begin
      wake_ev = '0;
      wake_ev[`WK_CMPA]   = cmp_a_flag_q;
      wake_ev[`WK_EXTIRQ] = ext_irq;
      wake_ev[`WK_DEBUG]  = debug_wake;
      wake_ev[`WK_SERIAL] = serial_act && serial_wake_en;
      wake_ev[`WK_GPIO]   = |((gpio_in ^ gpio_prev_q) & gpio_wake_mask_low);
   end
   assign deep_wake = |wake_ev;

   // Cause record: deep sleep and wake sequence events, clear ignored there
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         wake_cause_q <= '0;
      end else if (mode_q == sleep_timer_pkg::PM_DEEP ||
                   mode_q == sleep_timer_pkg::PM_RESTORE) begin
         wake_cause_q <= wake_cause_q | wake_ev;
      end else if (wake_cause_clr) begin
         wake_cause_q <= '0;
      end
   end

   // ========================================
   // Power mode state machine
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         mode_q <= sleep_timer_pkg::PM_ACTIVE;
         seq_q  <= 8'h00;
      end else begin
         case (mode_q)
            sleep_timer_pkg::PM_ACTIVE: begin
               seq_q <= 8'h00;
               if (sleep_req) begin
                  mode_q <= sleep_timer_pkg::PM_SAVE;
               end else if (idle_req) begin
                  mode_q <= sleep_timer_pkg::PM_IDLE;
               end
            end
            sleep_timer_pkg::PM_IDLE: begin
               // Any interrupt or debug command resumes
               if (any_irq || debug_wake) begin
                  mode_q <= sleep_timer_pkg::PM_ACTIVE;
               end
            end
            sleep_timer_pkg::PM_SAVE: begin
               // Processor registers copied to RAM
               if (seq_q == `SAVE_CYCLES - 8'h01) begin
                  mode_q <= sleep_timer_pkg::PM_DEEP;
                  seq_q  <= 8'h00;
               end else begin
                  seq_q <= seq_q + 8'h01;
               end
            end
            sleep_timer_pkg::PM_DEEP: begin
               if (deep_wake) begin
                  mode_q <= sleep_timer_pkg::PM_RESTORE;
               end
            end
            sleep_timer_pkg::PM_RESTORE: begin
               // Processor registers reloaded from RAM
               if (seq_q == `RESTORE_CYCLES - 8'h01) begin
                  mode_q <= sleep_timer_pkg::PM_ACTIVE;
                  seq_q  <= 8'h00;
               end else begin
                  seq_q <= seq_q + 8'h01;
               end
            end
            default: begin
               mode_q <= sleep_timer_pkg::PM_ACTIVE;
            end
         endcase
      end
   end

   // ========================================
   // Power outputs
   assign cpu_halt     = mode_q != sleep_timer_pkg::PM_ACTIVE;
   assign core_pwr_en  = mode_q != sleep_timer_pkg::PM_DEEP;
   // Core registers lost: held in reset while powered down
   assign core_rst     = mode_q == sleep_timer_pkg::PM_DEEP;
   assign regulator_en = mode_q != sleep_timer_pkg::PM_DEEP;
   assign regulator_output_pin = regulator_en;
   assign pads_ram_pwr = 1'b1;
   assign gpio_freeze  = mode_q == sleep_timer_pkg::PM_DEEP;
   // Receive held off through sleep and wake sequence
   assign serial_rx_en = mode_q == sleep_timer_pkg::PM_ACTIVE ||
                         mode_q == sleep_timer_pkg::PM_IDLE;
   assign cpu_save     = mode_q == sleep_timer_pkg::PM_SAVE;
   assign cpu_restore  = mode_q == sleep_timer_pkg::PM_RESTORE;

   // ========================================
   // Checks
   chk_cmpb_no_wake: assert property (@(posedge mclk) disable iff (sys_rst)
      (mode_q == sleep_timer_pkg::PM_DEEP && !(|wake_ev))
      |=> mode_q == sleep_timer_pkg::PM_DEEP)
      else $error("left deep sleep without wake event");
   chk_cmpa_set: assert property (@(posedge mclk) disable iff (sys_rst)
      (timer_tick && count_q == cmp_a) |=> cmp_a_flag_q)
      else $error("compare A flag not set");
   chk_cmpb_set: assert property (@(posedge mclk) disable iff (sys_rst)
      (timer_tick && count_q == cmp_b) |=> cmp_b_flag_q)
      else $error("compare B flag not set");
   chk_count_wrap: assert property (@(posedge mclk) disable iff (sys_rst)
      (timer_tick && count_q == 16'hFFFF) |=> count_q == 16'h0000)
      else $error("counter did not wrap");
   chk_reg_off: assert property (@(posedge mclk) disable iff (sys_rst)
      mode_q == sleep_timer_pkg::PM_DEEP |-> !regulator_output_pin
      && gpio_freeze)
      else $error("regulator on or gpio unfrozen in sleep");
   chk_save_len: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(cpu_save) |-> ##15 cpu_save ##1
      mode_q == sleep_timer_pkg::PM_DEEP)
      else $error("save sequence length wrong");
   chk_rx_hold: assert property (@(posedge mclk) disable iff (sys_rst)
      cpu_restore |-> !serial_rx_en)
      else $error("serial receive on during wake");
   chk_restore_len: assert property (@(posedge mclk) disable iff (sys_rst)
      $rose(cpu_restore) |-> ##15 cpu_restore ##1
      mode_q == sleep_timer_pkg::PM_ACTIVE)
      else $error("restore sequence length wrong");
   chk_idle_wake: assert property (@(posedge mclk) disable iff (sys_rst)
      (mode_q == sleep_timer_pkg::PM_IDLE && any_irq)
      |=> mode_q == sleep_timer_pkg::PM_ACTIVE)
      else $error("idle did not resume on interrupt");
   chk_cause_rec: assert property (@(posedge mclk) disable iff (sys_rst)
      (mode_q == sleep_timer_pkg::PM_DEEP && wake_ev[`WK_GPIO])
      |=> wake_cause_q[`WK_GPIO])
      else $error("wake cause not recorded");
   cov_deep_cycle: cover property (@(posedge mclk) disable iff (sys_rst)
      mode_q == sleep_timer_pkg::PM_RESTORE ##17
      mode_q == sleep_timer_pkg::PM_ACTIVE);
   cov_idle: cover property (@(posedge mclk) disable iff (sys_rst)
      mode_q == sleep_timer_pkg::PM_IDLE ##1
      mode_q == sleep_timer_pkg::PM_ACTIVE);
   cov_cmpa: cover property (@(posedge mclk) disable iff (sys_rst)
      $rose(cmp_a_flag_q));
   cov_cmpb_deep: cover property (@(posedge mclk) disable iff (sys_rst)
      mode_q == sleep_timer_pkg::PM_DEEP && $rose(cmp_b_flag_q));
   cov_gpio_wake: cover property (@(posedge mclk) disable iff (sys_rst)
      mode_q == sleep_timer_pkg::PM_DEEP && wake_ev[`WK_GPIO]);
endmodule

// ==== verification/sleep_timer_and_deep_sleep_wake_tb.sv ====
// Self-checking bench for the sleep timer and deep sleep power control
`timescale 1ns/1ps
`include "sleep_timer_map.svh"
module sleep_timer_and_deep_sleep_wake_tb;
   // ========================================
   // Stimulus
   logic        mclk = 1'b0, sys_rst = 1'b1;
   logic        rc_tick = 1'b0, xtal_tick = 1'b0, clk_sel = 1'b1;
   logic [3:0]  div_exp = 4'h0;
   logic [7:0]  cal_div = 8'h0A;
   logic [15:0] cmp_a = 16'h0002, cmp_b = 16'h0003;
   logic        cmp_a_clr = 1'b0, cmp_b_clr = 1'b0;
   logic        idle_req = 1'b0, sleep_req = 1'b0, any_irq = 1'b0;
   logic        ext_irq = 1'b0, debug_wake = 1'b0, serial_act = 1'b0;
   logic        serial_wake_en = 1'b1, wake_cause_clr = 1'b0;
   logic [15:0] gpio_in = 16'h0000, gpio_wake_mask_low = 16'h0020;
   // ========================================
   // Observed outputs
   logic [15:0] count_q;
   logic        cmp_a_flag_q, cmp_b_flag_q, rc_mgmt_tick;
   logic [4:0]  wake_cause_q;
   sleep_timer_pkg::power_mode_t mode_q;
   logic        cpu_halt, core_pwr_en, core_rst, regulator_en;
   logic        regulator_output_pin, pads_ram_pwr, gpio_freeze;
   logic        serial_rx_en, cpu_save, cpu_restore;
   // Bookkeeping
   int          n_mismatch = 0;
   int          samples_checked = 0;
   int          cycles = 0;
   int          n;
   int          exps[3] = '{0, 3, 15};
   int          pw[3] = '{0, 3, 10};

   sleep_timer_power dut (
      .mclk (mclk), .sys_rst (sys_rst),
      .rc_tick (rc_tick), .xtal_tick (xtal_tick),
      .clk_sel (clk_sel), .div_exp (div_exp), .cal_div (cal_div),
      .cmp_a (cmp_a), .cmp_b (cmp_b),
      .cmp_a_clr (cmp_a_clr), .cmp_b_clr (cmp_b_clr),
      .count_q (count_q), .cmp_a_flag_q (cmp_a_flag_q),
      .cmp_b_flag_q (cmp_b_flag_q), .rc_mgmt_tick (rc_mgmt_tick),
      .idle_req (idle_req), .sleep_req (sleep_req), .any_irq (any_irq),
      .ext_irq (ext_irq), .debug_wake (debug_wake),
      .serial_act (serial_act), .serial_wake_en (serial_wake_en),
      .gpio_in (gpio_in), .gpio_wake_mask_low (gpio_wake_mask_low),
      .wake_cause_clr (wake_cause_clr), .wake_cause_q (wake_cause_q),
      .mode_q (mode_q), .cpu_halt (cpu_halt),
      .core_pwr_en (core_pwr_en), .core_rst (core_rst),
      .regulator_en (regulator_en),
      .regulator_output_pin (regulator_output_pin),
      .pads_ram_pwr (pads_ram_pwr), .gpio_freeze (gpio_freeze),
      .serial_rx_en (serial_rx_en), .cpu_save (cpu_save),
      .cpu_restore (cpu_restore)
   );

   // 250 MHz clock
   always #2 mclk = ~mclk;

   // Cut a hang short
   always @(posedge mclk) begin
      cycles <= cycles + 1;
      if (cycles == 95000) begin
         n_mismatch = n_mismatch + 1;
         wrap_up();
      end
   end

   // Compare one value
   task automatic chk(logic [31:0] got, logic [31:0] exp);
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         n_mismatch = n_mismatch + 1;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // Verdict and end of run
   task automatic wrap_up();
      $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Let k edges pass, then settle
   task automatic step(int k);
      repeat (k) @(posedge mclk);
      #1;
   endtask

   // Reset held for eight edges
   task automatic do_reset();
      @(posedge mclk) sys_rst <= 1'b1;
      repeat (8) @(posedge mclk);
      sys_rst <= 1'b0;
      #1;
   endtask

   // Pulse an oscillator tick k times, four cycles apart
   task automatic tick(bit rc, int k);
      repeat (k) begin
         @(posedge mclk);
         if (rc)
            rc_tick <= 1'b1;
         else
            xtal_tick <= 1'b1;
         @(posedge mclk);
         rc_tick <= 1'b0;
         xtal_tick <= 1'b0;
         repeat (2) @(posedge mclk);
      end
      step(2);
   endtask

   // Count cycles spent in mode m, bounded
   task automatic dwell(sleep_timer_pkg::power_mode_t m);
      n = 0;
      while (mode_q === m && n < 40) begin
         step(1);
         n = n + 1;
      end
   endtask

   // Sleep request, save phase, then deep sleep outputs
   task automatic go_deep();
      @(posedge mclk) sleep_req <= 1'b1;
      @(posedge mclk) sleep_req <= 1'b0;
      #1;
      chk({mode_q, cpu_save, serial_rx_en}, {3'd2, 2'b10});
      dwell(sleep_timer_pkg::PM_SAVE);
      chk(n, 16);
      chk(mode_q, sleep_timer_pkg::PM_DEEP);
      chk({regulator_en, regulator_output_pin, gpio_freeze, core_pwr_en,
           core_rst, pads_ram_pwr}, 6'b001011);
   endtask

   // Restore phase, wake record, record clear
   task automatic finish_wake(logic [4:0] cause, bit extra);
      chk(mode_q, sleep_timer_pkg::PM_RESTORE);
      chk({cpu_restore, serial_rx_en}, 2'b10);
      if (extra) begin
         @(posedge mclk);
         debug_wake <= 1'b1;
         wake_cause_clr <= 1'b1;
         @(posedge mclk);
         debug_wake <= 1'b0;
         wake_cause_clr <= 1'b0;
         #1;
      end
      dwell(sleep_timer_pkg::PM_RESTORE);
      chk(n, extra ? 14 : 16);
      chk({mode_q, regulator_en, regulator_output_pin, gpio_freeze,
           serial_rx_en}, {3'd0, 4'b1101});
      chk(wake_cause_q, cause);
      @(posedge mclk) wake_cause_clr <= 1'b1;
      @(posedge mclk) wake_cause_clr <= 1'b0;
      #1;
      chk(wake_cause_q, 5'h00);
   endtask

   // Drive one wake source by index
   task automatic drive_src(int i, bit v);
      case (i)
         1: ext_irq <= v;
         2: debug_wake <= v;
         3: serial_act <= v;
         default: if (v) gpio_in <= gpio_in ^ 16'h0020;
      endcase
   endtask

   // ========================================
   // Main sequence
   initial begin
      do_reset();
      chk({count_q, cmp_a_flag_q, cmp_b_flag_q, wake_cause_q}, 0);
      chk({mode_q, cpu_halt, regulator_en, regulator_output_pin,
           gpio_freeze, serial_rx_en}, {3'd0, 5'b01101});
      @(posedge mclk) rc_tick <= 1'b1;
      #1;
      chk(rc_mgmt_tick, 1'b1);
      @(posedge mclk) rc_tick <= 1'b0;
      // Prescaler exponents, codes above ten clamp
      foreach (exps[i]) begin
         @(posedge mclk) div_exp <= 4'(exps[i]);
         do_reset();
         tick(0, (1 << pw[i]) - 1);
         chk(count_q, 16'h0000);
         tick(0, 1);
         chk(count_q, 16'h0001);
      end
      // Calibrated source ignores crystal ticks
      @(posedge mclk) begin
         clk_sel <= 1'b0;
         div_exp <= 4'h0;
      end
      do_reset();
      tick(0, 3);
      chk(count_q, 16'h0000);
      tick(1, 9);
      chk(count_q, 16'h0000);
      tick(1, 1);
      chk(count_q, 16'h0001);
      // Compare flags, clear, then full wrap
      @(posedge mclk) clk_sel <= 1'b1;
      do_reset();
      tick(0, 3);
      chk({cmp_a_flag_q, cmp_b_flag_q}, 2'b10);
      // Clear in the match cycle loses to the set
      @(posedge mclk) {xtal_tick, cmp_b_clr} <= 2'b11;
      @(posedge mclk) {xtal_tick, cmp_b_clr} <= 2'b00;
      step(2);
      chk({cmp_a_flag_q, cmp_b_flag_q}, 2'b11);
      for (int h = 0; h < 3; h++) begin
         @(posedge mclk) {cmp_a_clr, cmp_b_clr} <= 2'b11;
         @(posedge mclk) {cmp_a_clr, cmp_b_clr} <= 2'b00;
         step(2);
         chk({cmp_a_flag_q, cmp_b_flag_q}, 2'b00);
         if (h < 2) begin
            @(posedge mclk) xtal_tick <= 1'b1;
            repeat (32768) @(posedge mclk);
            xtal_tick <= 1'b0;
            step(4);
            chk(count_q, h == 0 ? 16'h8004 : 16'h0004);
            chk({cmp_a_flag_q, cmp_b_flag_q}, {2{h == 1}});
         end
      end
      // Idle halts until an interrupt; sleep refused there
      @(posedge mclk) idle_req <= 1'b1;
      @(posedge mclk) idle_req <= 1'b0;
      @(posedge mclk) sleep_req <= 1'b1;
      @(posedge mclk) sleep_req <= 1'b0;
      step(2);
      chk({mode_q, cpu_halt}, {3'd1, 1'b1});
      @(posedge mclk) any_irq <= 1'b1;
      @(posedge mclk) any_irq <= 1'b0;
      #1;
      chk({mode_q, cpu_halt}, {3'd0, 1'b0});
      // Compare B match in deep sleep does not wake, A does
      @(posedge mclk) {cmp_b, cmp_a} <= {16'h0005, 16'h0007};
      go_deep();
      tick(0, 3);
      chk({mode_q, cmp_b_flag_q}, {3'd3, 1'b1});
      @(posedge mclk) xtal_tick <= 1'b1;
      @(posedge mclk) xtal_tick <= 1'b0;
      #1;
      dwell(sleep_timer_pkg::PM_DEEP);
      finish_wake(5'h01, 1'b0);
      @(posedge mclk) {cmp_a_clr, cmp_b_clr} <= 2'b11;
      @(posedge mclk) {cmp_a_clr, cmp_b_clr} <= 2'b00;
      // Other wake sources, after ignored masked-off activity
      for (int i = 1; i < 5; i++) begin
         go_deep();
         if (i == 1) begin
            @(posedge mclk);
            serial_wake_en <= 1'b0;
            serial_act <= 1'b1;
            gpio_in <= gpio_in ^ 16'h0001;
            @(posedge mclk);
            serial_act <= 1'b0;
            serial_wake_en <= 1'b1;
            step(4);
            chk(mode_q, sleep_timer_pkg::PM_DEEP);
         end
         @(posedge mclk) drive_src(i, 1'b1);
         @(posedge mclk) drive_src(i, 1'b0);
         #1;
         dwell(sleep_timer_pkg::PM_DEEP);
         finish_wake(5'(1 << i) | (i == 1 ? 5'h04 : 5'h00), i == 1);
         // Receive back on after the serial wake
         if (i == 3)
            chk(serial_rx_en, 1'b1);
      end
      wrap_up();
   end
endmodule
